// ---- rtl/pmf_defs.svh ----
// Constants for the power control and buffer level register bank
`ifndef PMF_DEFS_SVH
`define PMF_DEFS_SVH

// ==========================================================
// Register offsets
`define PMF_ADDR_PRIMARY 8'h6b
`define PMF_ADDR_AXES 8'h6c
`define PMF_ADDR_LEVEL_HIGH 8'h72
`define PMF_ADDR_LEVEL_LOW 8'h73

// ==========================================================
// Reset values and fixed read values
`define PMF_PRIMARY_RESET 8'h40
`define PMF_AXES_RESET 8'h00
`define PMF_LEVEL_RESET 13'h0000
`define PMF_BYTE_ZERO 8'h00
`define PMF_HIGH_PAD 3'h0
`define PMF_AXES_ALL_OFF 3'h7

// ==========================================================
// Clock source select codes
`define PMF_SRC_OSC_LOW 3'h0
`define PMF_SRC_OSC_HIGH 3'h6
`define PMF_SRC_STOP 3'h7

// ==========================================================
// Timing: core clock and duty cycle base tick
`define PMF_CLK_HZ 100000000
`define PMF_BASE_TICK_HZ 1000
`define PMF_BASE_TICK_CYCLES (`PMF_CLK_HZ / `PMF_BASE_TICK_HZ)
`define PMF_DIV_WIDTH 17
`define PMF_DIV_ZERO 17'h00000
`define PMF_RATE_PAD 9'h000

`endif

// ---- rtl/pmf_pkg.sv ----
// Types shared by the power control and buffer level register bank
package pmf_pkg;

    // ==========================================================
    // Primary power control register layout
    typedef struct packed {
        logic device_reset;        // Self-clearing whole bank reset
        logic sleep;               // Sleep request
        logic accel_cycle;         // Accelerometer duty cycling
        logic gyro_standby;        // Gyro drive kept, sense off
        logic temp_sensor_off;     // Temperature sensor disable
        logic [2:0] clock_source_select; // Clock source code
    } pmf_primary_type;

    // ==========================================================
    // Axis power control register layout
    typedef struct packed {
        logic low_power_entry_inhibit;
        logic motion_engine_low_power_inhibit;
        logic accel_x_off;
        logic accel_y_off;
        logic accel_z_off;
        logic gyro_x_off;
        logic gyro_y_off;
        logic gyro_z_off;
    } pmf_axes_type;

    // ==========================================================
    // Register access request from the serial interface
    typedef struct packed {
        logic [7:0] addr;  // Register offset
        logic wr_en;       // One-cycle write strobe
        logic rd_en;       // One-cycle read strobe
        logic [7:0] wdata; // Write data
    } pmf_reg_req_type;

    // ==========================================================
    // Effective clock source, one-hot
    typedef enum logic [2:0] {
        PMF_CLK_OSC = 3'b001,
        PMF_CLK_PLL = 3'b010,
        PMF_CLK_STOP = 3'b100
    } pmf_clk_type;

endpackage : pmf_pkg

// ---- rtl/pmf_rate_div.sv ----
// Tick divider: one pulse every divisor+1 input ticks
`timescale 1ns/1ns
`include "pmf_defs.svh"

module pmf_rate_div #(
    parameter int WIDTH = `PMF_DIV_WIDTH
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clear,
    input wire logic tick_in,
    input wire logic [WIDTH-1:0] divisor,
    output logic pulse
);

    logic [WIDTH-1:0] count; // Ticks seen since the last pulse

    // ==========================================================
    // Count input ticks, restart on clear so phase is known
    always_ff @(posedge clk) begin
        if (!rst_b || clear) begin
            count <= '0;
            pulse <= 1'b0;
        end else if (tick_in) begin
            if (count >= divisor) begin
                // Compare with >= so a shrinking divisor cannot stall
                count <= '0;
                pulse <= 1'b1;
            end else begin
                count <= count + 1'b1;
                pulse <= 1'b0;
            end
        end else begin
            pulse <= 1'b0;
        end
    end

endmodule : pmf_rate_div

// ---- rtl/pmf_regs.sv ----
// Power control and buffer level register bank with duty cycling
//
// Notes on behaviour
// RULE1 - Reset bit write restores all register defaults
// RULE2 - Reset bit clears itself after reset completes
// RULE3 - Sleep bit defaults one; writing one sleeps
// RULE4 - Cycle mode wakes for samples at divider rate
// RULE5 - All accel axes off: wake, no samples
// RULE6 - Gyro standby keeps drive and PLL, sense off
// RULE7 - Temperature disable bit turns sensor off
// RULE8 - Codes one to five: PLL if ready
// RULE9 - Codes zero and six: internal oscillator
// RULE10 - Code seven stops clock, holds timing reset
// RULE11 - Low power entry when gyros and accel idle
// RULE12 - Motion engine low power mode unless inhibited
// RULE13 - Accel axis bits five to three disable
// RULE14 - Gyro axis bits two to zero disable
// RULE15 - High level byte top three bits zero
// RULE16 - Buffer level is thirteen bits, high/low
// RULE17 - High byte read latches both halves
// RULE18 - Host reads high byte before low byte
// RULE19 - Latch capture atomic with high byte read
`timescale 1ns/1ns
`include "pmf_defs.svh"

module pmf_regs
    import pmf_pkg::*;
#(
    parameter int BASE_TICK_CYCLES = `PMF_BASE_TICK_CYCLES
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire pmf_reg_req_type reg_req,
    output logic [7:0] reg_rdata,
    input wire logic [7:0] sample_rate_divider,
    input wire logic pll_ready,
    input wire logic [12:0] buffer_count,
    output logic chip_asleep,
    output logic cycle_wake,
    output logic accel_sample,
    output logic [2:0] accel_axis_on,
    output logic [2:0] gyro_sense_on,
    output logic gyro_drive_on,
    output logic pll_on,
    output logic temp_sensor_on,
    output pmf_clk_type clock_source,
    output logic timing_gen_reset,
    output logic motion_engine_low_power
);

    // ==========================================================
    // Register state
    pmf_primary_type primary;   // Primary power control, reset bit unused
    pmf_axes_type axes;         // Axis power control
    logic reset_pending;        // Soft reset in progress, read as bit 7
    logic [12:0] level_latch;   // Buffer level captured on high read

    // ==========================================================
    // Decoded strobes
    logic wr_primary;           // Write to primary control
    logic wr_axes;              // Write to axis control
    logic rd_high;              // Read of level high byte
    pmf_primary_type wr_view;   // Write data seen as primary layout

    // ==========================================================
    // Derived power state
    pmf_clk_type next_clock_source; // Effective clock for next cycle
    logic cycle_active;         // Duty cycling allowed to run
    logic [2:0] accel_on_mask;  // Enabled accel axes
    logic [2:0] gyro_on_mask;   // Enabled gyro axes
    logic any_accel;            // At least one accel axis enabled
    logic any_gyro;             // At least one gyro axis enabled
    logic clock_stopped;        // Timing generator must stay in reset
    logic base_tick;            // Base rate pulse
    logic wake_tick;            // Duty cycle wake pulse
    logic next_asleep;          // Sleep state for next cycle
    logic [7:0] next_rdata;     // Read data for next cycle

    assign wr_view = reg_req.wdata;
    assign wr_primary = reg_req.wr_en && (reg_req.addr == `PMF_ADDR_PRIMARY);
    assign wr_axes = reg_req.wr_en && (reg_req.addr == `PMF_ADDR_AXES);
    assign rd_high = reg_req.rd_en && (reg_req.addr == `PMF_ADDR_LEVEL_HIGH);

    // ==========================================================
    // Soft reset sequencing: the write takes one cycle to land,
    // then every register returns to default in the next cycle
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            reset_pending <= 1'b0;
        end else if (reset_pending) begin
            // Reset done, bit drops to zero by itself
            reset_pending <= 1'b0; // RULE2
        end else if (wr_primary && wr_view.device_reset) begin
            reset_pending <= 1'b1; // RULE1
        end
    end

    // ==========================================================
    // Primary control register
    always_ff @(posedge clk) begin
        if (!rst_b || reset_pending) begin
            // Default has sleep set, so the part starts asleep
            primary <= `PMF_PRIMARY_RESET; // RULE1 RULE3
        end else if (wr_primary) begin
            primary <= wr_view; // RULE3
            // Reset bit is never stored; reset_pending stands for it
            primary.device_reset <= 1'b0;
        end
    end

    // ==========================================================
    // Axis control register
    always_ff @(posedge clk) begin
        if (!rst_b || reset_pending) begin
            axes <= `PMF_AXES_RESET; // RULE1
        end else if (wr_axes) begin
            axes <= reg_req.wdata; // RULE13 RULE14
        end
    end

    // ==========================================================
    // Buffer level latch: the high read samples the live count
    // in the same edge that answers, so both halves match even
    // when the buffer is being written in that very cycle
    always_ff @(posedge clk) begin
        if (!rst_b || reset_pending) begin
            level_latch <= `PMF_LEVEL_RESET;
        end else if (rd_high) begin
            level_latch <= buffer_count; // RULE17 RULE19
        end
    end

    // ==========================================================
    // Read data mux
    always_comb begin
        next_rdata = `PMF_BYTE_ZERO;
        if (reg_req.rd_en) begin
            case (reg_req.addr)
                `PMF_ADDR_PRIMARY: begin
                    // Show the reset bit while it is still working
                    next_rdata = primary;
                    next_rdata[7] = reset_pending; // RULE2
                end
                `PMF_ADDR_AXES: begin
                    next_rdata = axes;
                end
                `PMF_ADDR_LEVEL_HIGH: begin
                    // Live count, same value the latch takes now
                    next_rdata = {`PMF_HIGH_PAD,
                        buffer_count[12:8]}; // RULE15 RULE16 RULE19
                end
                `PMF_ADDR_LEVEL_LOW: begin
                    // Low half only refreshes through a high read
                    next_rdata = level_latch[7:0]; // RULE16 RULE18
                end
                default: begin
                    // Unmapped offsets read as zero
                    next_rdata = `PMF_BYTE_ZERO;
                end
            endcase
        end
    end

    // ==========================================================
    // Read data register, holds until the next read
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            reg_rdata <= `PMF_BYTE_ZERO;
        end else if (reg_req.rd_en) begin
            reg_rdata <= next_rdata;
        end
    end

    // ==========================================================
    // Clock source decode
    always_comb begin
        next_clock_source = PMF_CLK_OSC;
        case (primary.clock_source_select)
            `PMF_SRC_OSC_LOW, `PMF_SRC_OSC_HIGH: begin
                next_clock_source = PMF_CLK_OSC; // RULE9
            end
            `PMF_SRC_STOP: begin
                next_clock_source = PMF_CLK_STOP; // RULE10
            end
            default: begin
                // Codes one to five fall back until the PLL locks
                next_clock_source = pll_ready ?
                    PMF_CLK_PLL : PMF_CLK_OSC; // RULE8
            end
        endcase
    end

    assign clock_stopped = (primary.clock_source_select == `PMF_SRC_STOP);

    // ==========================================================
    // Axis enables and duty cycle qualification
    assign accel_on_mask = ~{axes.accel_x_off, axes.accel_y_off,
        axes.accel_z_off}; // RULE13
    assign gyro_on_mask = ~{axes.gyro_x_off, axes.gyro_y_off,
        axes.gyro_z_off}; // RULE14
    assign any_accel = (accel_on_mask != `PMF_HIGH_PAD);
    assign any_gyro = (gyro_on_mask != `PMF_HIGH_PAD);
    // Sleep and standby both stop the cycling
    assign cycle_active = primary.accel_cycle && !primary.sleep
        && !primary.gyro_standby && !clock_stopped; // RULE4

    // ==========================================================
    // Base tick from the core clock; held in reset when the clock
    // is stopped so the timing generator restarts from zero
    pmf_rate_div #(
        .WIDTH(`PMF_DIV_WIDTH)
    ) u_base_div (
        .clk(clk),
        .rst_b(rst_b),
        .clear(clock_stopped), // RULE10
        .tick_in(1'b1),
        .divisor(`PMF_DIV_WIDTH'(BASE_TICK_CYCLES - 1)),
        .pulse(base_tick)
    );

    // ==========================================================
    // Wake rate: one wake per sample_rate_divider+1 base ticks
    pmf_rate_div #(
        .WIDTH(`PMF_DIV_WIDTH)
    ) u_wake_div (
        .clk(clk),
        .rst_b(rst_b),
        .clear(!cycle_active), // RULE4
        .tick_in(base_tick),
        .divisor({`PMF_RATE_PAD, sample_rate_divider}),
        .pulse(wake_tick)
    );

    // ==========================================================
    // Sleep state: explicit sleep, or idle between cycle samples
    // with the gyros off; a gap of one cycle per wake is accepted
    always_comb begin
        next_asleep = primary.sleep; // RULE3
        if (cycle_active && !axes.low_power_entry_inhibit
            && !any_gyro && !wake_tick) begin
            next_asleep = 1'b1; // RULE11
        end
    end

    // ==========================================================
    // Duty cycle pulses
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cycle_wake <= 1'b0;
            accel_sample <= 1'b0;
        end else begin
            // Wake happens even with every accel axis off
            cycle_wake <= wake_tick && cycle_active; // RULE5
            accel_sample <= wake_tick && cycle_active
                && any_accel; // RULE4 RULE5
        end
    end

    // ==========================================================
    // Sensor power outputs
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            chip_asleep <= 1'b1;
            accel_axis_on <= `PMF_HIGH_PAD;
            gyro_sense_on <= `PMF_HIGH_PAD;
            gyro_drive_on <= 1'b0;
            pll_on <= 1'b0;
            temp_sensor_on <= 1'b0;
        end else begin
            chip_asleep <= next_asleep;
            accel_axis_on <= (primary.sleep || clock_stopped) ?
                `PMF_HIGH_PAD : accel_on_mask; // RULE13
            // Standby drops only the sense paths
            gyro_sense_on <= (primary.sleep || primary.gyro_standby
                || clock_stopped) ?
                `PMF_HIGH_PAD : gyro_on_mask; // RULE6 RULE14
            gyro_drive_on <= !primary.sleep && !clock_stopped
                && (any_gyro || primary.gyro_standby); // RULE6
            pll_on <= !primary.sleep && !clock_stopped
                && (any_gyro || primary.gyro_standby); // RULE6
            temp_sensor_on <= !primary.temp_sensor_off
                && !primary.sleep; // RULE7
        end
    end

    // ==========================================================
    // Clock and motion engine outputs
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            clock_source <= PMF_CLK_OSC;
            timing_gen_reset <= 1'b0;
            motion_engine_low_power <= 1'b0;
        end else begin
            clock_source <= next_clock_source; // RULE8 RULE9 RULE10
            timing_gen_reset <= clock_stopped; // RULE10
            motion_engine_low_power <= primary.accel_cycle
                && !axes.motion_engine_low_power_inhibit; // RULE12
        end
    end

endmodule : pmf_regs

// ---- sim/pmf_host.sv ----
// Host model driving the register request port
`timescale 1ns/1ns

module pmf_host
    import pmf_pkg::*;
(
    input wire logic clk,
    output pmf_reg_req_type reg_req,
    input wire logic [7:0] reg_rdata
);
    // ==========================================================
    // Idle bus: strobes low, address flipped on release, data flipped on write release and read launch
    initial reg_req = '{8'h00, 1'h0, 1'h0, 8'h00};

    // One-cycle write strobe, launched off the falling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_req <= '{a, 1'h1, 1'h0, d};
        @(negedge clk);
        reg_req <= '{~a, 1'h0, 1'h0, ~d};
    endtask : wr

    // Read data is registered, so it is taken one edge later
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_req <= '{a, 1'h0, 1'h1, ~reg_req.wdata};
        @(negedge clk);
        d = reg_rdata;
        reg_req <= '{~a, 1'h0, 1'h0, reg_req.wdata};
    endtask : rd

    // High byte first, since only it refreshes the latch
    task automatic rd_count(output logic [12:0] v);
        logic [7:0] h;
        logic [7:0] l;
        rd(8'h72, h);
        rd(8'h73, l);
        v = {h[4:0], l};
    endtask : rd_count
endmodule : pmf_host

// ---- sim/pmf_regs_bench.sv ----
// Testbench for the power control and buffer level register bank
`timescale 1ns/1ns

module pmf_regs_bench;
    import pmf_pkg::*;
    localparam int BT = 8; // Short base tick keeps duty cycling quick
    logic clk, rst_b, pll_ready, chip_asleep, cycle_wake, accel_sample;
    logic gyro_drive_on, pll_on, temp_sensor_on, timing_gen_reset, mel;
    logic [7:0] reg_rdata, div, d;
    logic [12:0] cnt, v;
    logic [2:0] accel_axis_on, gyro_sense_on;
    logic [15:0] nw, ns, na;
    pmf_clk_type clock_source, ec;
    pmf_reg_req_type reg_req;
    int n_mismatch = 0;
    int cmp_count = 0;

    // ==========================================================
    // Design, host model, clock
    pmf_regs #(.BASE_TICK_CYCLES(BT)) dut (.clk(clk), .rst_b(rst_b),
        .reg_req(reg_req), .reg_rdata(reg_rdata),
        .sample_rate_divider(div), .pll_ready(pll_ready),
        .buffer_count(cnt), .chip_asleep(chip_asleep),
        .cycle_wake(cycle_wake), .accel_sample(accel_sample),
        .accel_axis_on(accel_axis_on), .gyro_sense_on(gyro_sense_on),
        .gyro_drive_on(gyro_drive_on), .pll_on(pll_on),
        .temp_sensor_on(temp_sensor_on), .clock_source(clock_source),
        .timing_gen_reset(timing_gen_reset),
        .motion_engine_low_power(mel));
    pmf_host host (.clk(clk), .reg_req(reg_req), .reg_rdata(reg_rdata));
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end

    // ==========================================================
    // Compare, verdict, helpers
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic test_done;
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : test_done
    // Write, then let the registered outputs settle
    task automatic wo(input logic [7:0] a, input logic [7:0] dd);
        host.wr(a, dd);
        @(negedge clk);
    endtask : wo
    // Count wakes, samples and asleep cycles over a window
    task automatic win(input int n);
        nw = 16'h0000;
        ns = 16'h0000;
        na = 16'h0000;
        repeat (n) begin
            @(negedge clk);
            if (cycle_wake) nw++;
            if (accel_sample) ns++;
            if (chip_asleep) na++;
        end
    endtask : win

    // Hang guard: whole run is about a thousand cycles
    initial begin
        #100000;
        n_mismatch++;
        test_done();
    end

    // ==========================================================
    // Main sequence
    initial begin
        rst_b = 1'h0;
        pll_ready = 1'h1;
        div = 8'h01;
        cnt = 13'h0000;
        repeat (6) @(negedge clk);
        rst_b = 1'h1;
        @(negedge clk);
        chk(chip_asleep, 16'h1);
        host.rd(8'h6b, d);
        chk(d, 16'h40);
        host.rd(8'h73, d);
        chk(d, 16'h00);
        host.rd(8'h10, d);
        chk(d, 16'h00);
        // Axis bits, then wake with code zero
        wo(8'h6c, 8'h15);
        chk(accel_axis_on, 16'h0);
        wo(8'h6b, 8'h00);
        chk(accel_axis_on, 16'h5);
        chk(gyro_sense_on, 16'h2);
        host.rd(8'h6c, d);
        chk(d, 16'h15);
        wo(8'h6b, 8'h08);
        chk(temp_sensor_on, 16'h0);
        wo(8'h6b, 8'h10);
        chk(gyro_sense_on, 16'h0);
        chk(gyro_drive_on & pll_on, 16'h1);
        // Every clock code, with the pll ready and not
        for (int i = 0; i < 16; i++) begin
            pll_ready = i[3];
            wo(8'h6b, {5'h00, i[2:0]});
            if (i[2:0] == 3'h7) ec = PMF_CLK_STOP;
            else if (i[2:0] == 3'h0 || i[2:0] == 3'h6 || !i[3])
                ec = PMF_CLK_OSC;
            else ec = PMF_CLK_PLL;
            chk(clock_source, ec);
            chk(timing_gen_reset, i[2:0] == 3'h7);
        end
        // Level latch: high read freezes the low half
        cnt = 13'h1abc;
        host.rd(8'h72, d);
        chk(d, 16'h1a);
        cnt = 13'h0123;
        host.rd(8'h73, d);
        chk(d, 16'hbc);
        cnt = 13'h1fff;
        host.rd_count(v);
        chk(v, 16'h1fff);
        // Duty cycling: one wake per 16 cycles
        wo(8'h6c, 8'h07);
        wo(8'h6b, 8'h20);
        win(40);
        win(160);
        chk(nw, 16'd10);
        chk(ns, 16'd10);
        chk(na, 16'd150);
        chk(mel, 16'h1);
        wo(8'h6c, 8'h3f);
        win(160);
        chk(nw, 16'd10);
        chk(ns, 16'd0);
        wo(8'h6c, 8'hc7);
        win(160);
        chk(na, 16'd0);
        chk(mel, 16'h0);
        // Gyro standby and sleep also stop the cycling
        wo(8'h6b, 8'h30);
        win(160);
        chk(nw, 16'd0);
        wo(8'h6b, 8'h60);
        win(160);
        chk(nw, 16'd0);
        // Soft reset with non-default contents
        wo(8'h6c, 8'h15);
        wo(8'h6b, 8'h83);
        host.rd(8'h6b, d);
        chk(d, 16'h40);
        host.rd(8'h6c, d);
        chk(d, 16'h00);
        test_done();
    end
endmodule : pmf_regs_bench

// ---- sim/pmf_regs_chk.sv ----
// Checker for the power control and buffer level register bank
`timescale 1ns/1ns

module pmf_regs_chk
    import pmf_pkg::*;
#(
    parameter int BASE_TICK_CYCLES = 8
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire pmf_reg_req_type reg_req,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] sample_rate_divider,
    input wire logic pll_ready,
    input wire logic [12:0] buffer_count,
    input wire logic chip_asleep,
    input wire logic cycle_wake,
    input wire logic accel_sample,
    input wire logic [2:0] accel_axis_on,
    input wire logic [2:0] gyro_sense_on,
    input wire logic gyro_drive_on,
    input wire logic pll_on,
    input wire logic temp_sensor_on,
    input wire pmf_clk_type clock_source,
    input wire logic timing_gen_reset,
    input wire logic motion_engine_low_power
);
    // ==========================================================
    // Request sequences
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    sequence s_hi;
        reg_req.rd_en && reg_req.addr == 8'h72;
    endsequence
    sequence s_lo;
        reg_req.rd_en && reg_req.addr == 8'h73;
    endsequence
    sequence s_rdp;
        reg_req.rd_en && reg_req.addr == 8'h6b;
    endsequence
    // Plain primary write; soft reset writes are kept apart
    sequence s_wp;
        reg_req.wr_en && reg_req.addr == 8'h6b && !reg_req.wdata[7];
    endsequence
    sequence s_srst;
        reg_req.wr_en && reg_req.addr == 8'h6b && reg_req.wdata[7];
    endsequence

    // ==========================================================
    // Assertions; outputs settle two edges after a plain write, three after a soft reset write
    a_high_pad: assert property (
        s_hi |=> reg_rdata == {3'h0, $past(buffer_count[12:8])})
        else $error("high level byte wrong");
    a_low_latch: assert property (
        s_hi ##2 s_lo |=> reg_rdata == $past(buffer_count[7:0], 3))
        else $error("low level byte not latched");
    a_clock_pick: assert property (
        s_wp and reg_req.wdata[2:0] != 3'h7 |-> ##2 clock_source ==
        (($past(reg_req.wdata[2:0], 2) == 3'h0 || !$past(pll_ready) ||
        $past(reg_req.wdata[2:0], 2) == 3'h6) ? PMF_CLK_OSC : PMF_CLK_PLL))
        else $error("clock source wrong");
    a_stop_hold: assert property (
        s_wp and reg_req.wdata[2:0] == 3'h7 |-> ##2
        timing_gen_reset && clock_source == PMF_CLK_STOP)
        else $error("stop code not honoured");
    a_gyro_standby: assert property (
        s_wp and reg_req.wdata[6:4] == 3'h1 and reg_req.wdata[2:0] != 3'h7
        |-> ##2 gyro_sense_on == 3'h0 && gyro_drive_on && pll_on)
        else $error("standby outputs wrong");
    a_temp_off: assert property (
        s_wp |-> ##2 temp_sensor_on ==
        !($past(reg_req.wdata[3], 2) || $past(reg_req.wdata[6], 2)))
        else $error("temperature enable wrong");
    a_soft_default: assert property (
        s_srst |-> ##3 chip_asleep && !temp_sensor_on &&
        clock_source == PMF_CLK_OSC && accel_axis_on == 3'h0)
        else $error("soft reset defaults missing");
    a_self_clear: assert property (
        s_srst ##[2:8] s_rdp |=> reg_rdata[7] == 1'h0)
        else $error("reset bit did not clear");
    a_wake_sample: assert property (
        accel_sample |-> cycle_wake && !chip_asleep)
        else $error("sample outside a wake");
endmodule : pmf_regs_chk

bind pmf_regs pmf_regs_chk #(.BASE_TICK_CYCLES(BASE_TICK_CYCLES)) u_chk (
    .clk(clk), .rst_b(rst_b), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .sample_rate_divider(sample_rate_divider), .pll_ready(pll_ready),
    .buffer_count(buffer_count), .chip_asleep(chip_asleep),
    .cycle_wake(cycle_wake), .accel_sample(accel_sample),
    .accel_axis_on(accel_axis_on), .gyro_sense_on(gyro_sense_on),
    .gyro_drive_on(gyro_drive_on), .pll_on(pll_on),
    .temp_sensor_on(temp_sensor_on), .clock_source(clock_source),
    .timing_gen_reset(timing_gen_reset),
    .motion_engine_low_power(motion_engine_low_power));
